// File: rcs_pkg.sv
/*
 * Shared constants and types for the reference clock switchover block.
 * Assumes nothing beyond a SystemVerilog compiler; imported by name only.
 */
package rcs_pkg;
    // =========================================================
    // Modes, as driven on the MODE port
    typedef enum logic [1:0] {
        RCS_MODE_AUTO = 2'h0,
        RCS_MODE_MANUAL = 2'h1,
        RCS_MODE_OVERRIDE = 2'h2
    } rcs_mode_e;

    // =========================================================
    // Counts
    // Foreign edges seen with no own edge before an input is declared stopped;
    // within a 20% spread two foreign edges can fall between own edges
    localparam logic [1:0] RCS_STOP_EDGES = 2'h3;
    // Target-input cycles the manual control must stay low
    localparam int RCS_HOLD_CYCLES = 3;
    // Reset values
    localparam logic RCS_SEL_RST = 1'b0;
    localparam logic [1:0] RCS_SENSE_RST = 2'h0;
    // Synchroniser presets: references low, manual control high
    localparam logic [2:0] RCS_PIN_RST = 3'h4;

    // =========================================================
    // Switchover sequencer states
    typedef enum logic [2:0] {
        RCS_IDLE,
        RCS_HOLD,
        RCS_GATE_OLD,
        RCS_WAIT_NEW
    } rcs_state_e;
endpackage

// File: rcs_top.sv
/*
 * Reference clock switchover in front of a PLL: clock sense per input,
 * automatic, manual and override switching, stopped flags, selection status.
 * Assumes CLK is much faster than either reference so each reference can be
 * sampled as a level; both references and the manual control are asynchronous.
 */
//
// Contract
// - Auto mode switches to the other input when the selected one stops.
// - Manual mode swaps after a control fall held low three target cycles.
// - Override mode: control low beats automatic switching and blocks further switches.
// - Each input has its own stopped flag from clock sense.
// - Stopped flags are unreliable beyond 20% frequency difference; selection stays valid.
// - A status output shows whether primary or backup feeds the PLL.
// - Automatic switching may repeat back and forth without limit.
// - No switchover when the other input is idle too; flags then invalid.
// - About two cycles without toggling raises the flag and switches over.
// - Gate output on old falling edge, mux and status change on new falling edge.
// - Manual switch with healthy inputs inverts selection, flags stay low.
// - Only the control falling edge triggers; each later fall swaps again.
// - Switch waits for a stopped target input to toggle again before completing.
// - With a delay, hold is three target cycles plus the delay cycles.
`timescale 1ns/10ps
module rcs_top #(
    parameter int DLY_W = 8
) (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST_B,
    // Reference inputs, asynchronous to CLK
    input wire logic REF_IN_PRIMARY,
    input wire logic REF_IN_BACKUP,
    // Fabric control
    input wire logic MANUAL_SWITCH_B,
    input wire logic [1:0] MODE,
    input wire logic [DLY_W-1:0] SWITCH_DELAY,
    // Reference to the PLL and status
    output logic REF_OUT,
    output logic PRIMARY_STOPPED_FLAG,
    output logic BACKUP_STOPPED_FLAG,
    output logic ACTIVE_BACKUP,
    output logic SWITCH_BUSY
);
    generate
        if (DLY_W < 1 || DLY_W > 16)
        begin : g_bad_dly
            $error("rcs_top: DLY_W must be 1 to 16");
        end
    endgenerate

    // =========================================================
    // Reset release
    logic rst_s1_ff;
    logic rst_s2_ff;
    logic rst_n;

    always_ff @(posedge CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            rst_s1_ff <= 1'b0;
            rst_s2_ff <= 1'b0;
        end
        else
        begin
            rst_s1_ff <= 1'b1;
            rst_s2_ff <= rst_s1_ff;
        end
    end
    assign rst_n = rst_s2_ff;

    // =========================================================
    // Input capture: index 0 primary, 1 backup, 2 manual control
    logic [2:0] pin_in;
    logic [2:0] s1_ff;
    logic [2:0] s2_ff;
    logic [2:0] s3_ff;
    logic [2:0] lvl_ff;
    logic [2:0] nxt_lvl;
    logic [2:0] rise;
    logic [2:0] fall;

    assign pin_in = {MANUAL_SWITCH_B, REF_IN_BACKUP, REF_IN_PRIMARY};

    always_comb
    begin
        nxt_lvl = lvl_ff;
        for (int i = 0; i < 3; i++)
        begin
            // A change counts only once the last two stages agree
            if (s2_ff[i] == s3_ff[i])
            begin
                nxt_lvl[i] = s3_ff[i];
            end
        end
    end

    always_ff @(posedge CLK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s1_ff <= rcs_pkg::RCS_PIN_RST;
            s2_ff <= rcs_pkg::RCS_PIN_RST;
            s3_ff <= rcs_pkg::RCS_PIN_RST;
            lvl_ff <= rcs_pkg::RCS_PIN_RST;
        end
        else
        begin
            s1_ff <= pin_in;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            lvl_ff <= nxt_lvl;
        end
    end

    assign rise = nxt_lvl & ~lvl_ff;
    assign fall = ~nxt_lvl & lvl_ff;

    // =========================================================
    // Clock sense: an input is stopped once the other input has risen
    // three times with no rise of its own. Measuring against the other input
    // keeps the sense frequency-independent, but makes it meaningless when
    // the two differ widely, and freezes it when both are idle.
    logic [1:0] stop_ff;
    logic [1:0] nxt_stop;

    generate
        for (genvar g = 0; g < 2; g++)
        begin : g_sense
            logic [1:0] cnt_ff;
            logic [1:0] nxt_cnt;

            always_comb
            begin
                nxt_cnt = cnt_ff;
                if (rise[g])
                begin
                    nxt_cnt = rcs_pkg::RCS_SENSE_RST;
                end
                else if (rise[1-g] && cnt_ff != rcs_pkg::RCS_STOP_EDGES)
                begin
                    nxt_cnt = cnt_ff + 2'h1;
                end
                nxt_stop[g] = (nxt_cnt == rcs_pkg::RCS_STOP_EDGES);
            end

            always_ff @(posedge CLK or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    cnt_ff <= rcs_pkg::RCS_SENSE_RST;
                end
                else
                begin
                    cnt_ff <= nxt_cnt;
                end
            end
        end
    endgenerate

    // =========================================================
    // Switchover sequencer
    rcs_pkg::rcs_state_e state_ff;
    rcs_pkg::rcs_state_e nxt_state;
    logic sel_ff;
    logic nxt_sel;
    logic gate_ff;
    logic nxt_gate;
    logic ref_ff;
    logic nxt_ref;
    logic [DLY_W:0] hold_ff;
    logic [DLY_W:0] nxt_hold;
    logic [DLY_W:0] hold_need;
    logic auto_en;
    logic man_en;
    logic auto_req;
    logic man_low;

    assign auto_en = (MODE == rcs_pkg::RCS_MODE_AUTO) || (MODE == rcs_pkg::RCS_MODE_OVERRIDE);
    assign man_en = (MODE == rcs_pkg::RCS_MODE_MANUAL) || (MODE == rcs_pkg::RCS_MODE_OVERRIDE);
    assign man_low = ~lvl_ff[2];
    assign hold_need = {1'b0, SWITCH_DELAY} + (DLY_W+1)'(rcs_pkg::RCS_HOLD_CYCLES);

    // Override: a low control blocks automatic action outright
    assign auto_req = auto_en && stop_ff[sel_ff] && !stop_ff[~sel_ff]
                      && !(MODE == rcs_pkg::RCS_MODE_OVERRIDE && man_low);

    always_comb
    begin
        nxt_state = state_ff;
        nxt_sel = sel_ff;
        nxt_gate = gate_ff;
        nxt_hold = hold_ff;
        unique case (state_ff)
            rcs_pkg::RCS_IDLE:
            begin
                nxt_hold = '0;
                if (man_en && fall[2])
                begin
                    nxt_state = rcs_pkg::RCS_HOLD;
                end
                else if (auto_req)
                begin
                    nxt_state = rcs_pkg::RCS_GATE_OLD;
                end
            end
            rcs_pkg::RCS_HOLD:
            begin
                // Counted in target-input cycles; a stopped target stalls it
                if (!man_low)
                begin
                    nxt_state = rcs_pkg::RCS_IDLE;
                end
                else if (hold_ff >= hold_need)
                begin
                    nxt_state = rcs_pkg::RCS_GATE_OLD;
                end
                else if (rise[~sel_ff])
                begin
                    nxt_hold = hold_ff + (DLY_W+1)'(1);
                end
            end
            rcs_pkg::RCS_GATE_OLD:
            begin
                // A dead old input never falls, so its stop also sets the gate
                if (fall[sel_ff] || stop_ff[sel_ff])
                begin
                    nxt_gate = 1'b1;
                    nxt_state = rcs_pkg::RCS_WAIT_NEW;
                end
            end
            rcs_pkg::RCS_WAIT_NEW:
            begin
                if (fall[~sel_ff])
                begin
                    nxt_sel = ~sel_ff;
                    nxt_gate = 1'b0;
                    nxt_state = rcs_pkg::RCS_IDLE;
                end
            end
        endcase
    end

    always_comb
    begin
        nxt_ref = 1'b0;
        if (!nxt_gate)
        begin
            nxt_ref = nxt_sel ? nxt_lvl[1] : nxt_lvl[0];
        end
    end

    always_ff @(posedge CLK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_ff <= rcs_pkg::RCS_IDLE;
            sel_ff <= rcs_pkg::RCS_SEL_RST;
            gate_ff <= 1'b0;
            ref_ff <= 1'b0;
            hold_ff <= '0;
            stop_ff <= rcs_pkg::RCS_SENSE_RST;
        end
        else
        begin
            state_ff <= nxt_state;
            sel_ff <= nxt_sel;
            gate_ff <= nxt_gate;
            ref_ff <= nxt_ref;
            hold_ff <= nxt_hold;
            stop_ff <= nxt_stop;
        end
    end

    // =========================================================
    // Outputs
    assign REF_OUT = ref_ff;
    assign PRIMARY_STOPPED_FLAG = stop_ff[0];
    assign BACKUP_STOPPED_FLAG = stop_ff[1];
    assign ACTIVE_BACKUP = sel_ff;
    assign SWITCH_BUSY = (state_ff != rcs_pkg::RCS_IDLE);
endmodule

// File: rcs_ref_src.sv
/* Two gated reference oscillators and a stand-in for the PLL behind the block.
 * Assumes the bench drives the gates; a gated source rests low. */
`timescale 1ns/10ps
module rcs_ref_src (
    // Gates and backup speed select
    input wire logic en_p,
    input wire logic en_b,
    input wire logic slow_bkp,
    // Block outputs seen by the PLL
    input wire logic act,
    input wire logic ref_out,
    // Clocks and lock
    output logic ref_p,
    output logic ref_b,
    output logic pll_lock
);
    logic pll_rst = 1'b0;
    int lock_cnt = 0;

    // =========================================================
    // Oscillators
    // Fractional start phases keep every edge clear of CLK
    initial
    begin
        ref_p = 1'b0;
        #0.5;
        forever #20 ref_p = en_p & ~ref_p;
    end
    // Slow backup is 2.5 times the primary period, beyond clock sense reach
    initial
    begin
        ref_b = 1'b0;
        #0.7;
        forever #(slow_bkp ? 50 : 22) ref_b = en_b & ~ref_b;
    end

    // =========================================================
    // PLL stand-in: 12 ns reset starting at each switch, relock on four rises
    always @(act)
    begin
        pll_rst = 1'b1;
        #12;
        pll_rst = 1'b0;
    end
    always @(posedge ref_out or posedge pll_rst)
    begin
        if (pll_rst)
            lock_cnt = 0;
        else if (lock_cnt < 4)
            lock_cnt = lock_cnt + 1;
    end
    assign pll_lock = (lock_cnt == 4);
endmodule

// File: rcs_top_assertions.sv
/* Port checker for rcs_top, bound to every instance.
 * Assumes reference periods of ten to twenty-five CLK cycles. */
`timescale 1ns/10ps
module rcs_chk (
    // Clock and reset
    input wire logic CLK,
    input wire logic RST_B,
    // Watched ports
    input wire logic REF_IN_PRIMARY,
    input wire logic REF_IN_BACKUP,
    input wire logic MANUAL_SWITCH_B,
    input wire logic [1:0] MODE,
    input wire logic REF_OUT,
    input wire logic PRIMARY_STOPPED_FLAG,
    input wire logic BACKUP_STOPPED_FLAG,
    input wire logic ACTIVE_BACKUP,
    input wire logic SWITCH_BUSY
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_B);
    // ==========
    // Switching
    property p_done;
        $changed(ACTIVE_BACKUP) |-> $past(SWITCH_BUSY) && !SWITCH_BUSY;
    endproperty
    a_done: assert property (p_done) else $error("select moved outside a switch");
    property p_gate;
        $changed(ACTIVE_BACKUP) |-> !$past(REF_OUT);
    endproperty
    a_gate: assert property (p_gate) else $error("output not gated");
    property p_auto;
        MODE == rcs_pkg::RCS_MODE_AUTO && !SWITCH_BUSY && !ACTIVE_BACKUP
            && PRIMARY_STOPPED_FLAG && !BACKUP_STOPPED_FLAG |=> SWITCH_BUSY;
    endproperty
    a_auto: assert property (p_auto) else $error("no auto switch");
    property p_ovr;
        (MODE == rcs_pkg::RCS_MODE_OVERRIDE && !MANUAL_SWITCH_B) [*8]
            |=> !$rose(SWITCH_BUSY);
    endproperty
    a_ovr: assert property (p_ovr) else $error("switch while held low");
    property p_trig;
        $rose(SWITCH_BUSY) && MODE == rcs_pkg::RCS_MODE_MANUAL
            |-> !$past(MANUAL_SWITCH_B) && !$past(MANUAL_SWITCH_B, 2);
    endproperty
    a_trig: assert property (p_trig) else $error("start without low control");
    property p_hold;
        $rose(SWITCH_BUSY) && MODE == rcs_pkg::RCS_MODE_MANUAL |=> SWITCH_BUSY [*8];
    endproperty
    a_hold: assert property (p_hold) else $error("hold too short");
    // ==========
    // Clock sense, then cover points
    property p_pflag;
        $rose(PRIMARY_STOPPED_FLAG) |-> !$past(REF_IN_PRIMARY, 4) && !$past(REF_IN_PRIMARY, 8);
    endproperty
    a_pflag: assert property (p_pflag) else $error("primary flag while running");
    property p_bflag;
        $rose(BACKUP_STOPPED_FLAG) |-> !$past(REF_IN_BACKUP, 4) && !$past(REF_IN_BACKUP, 8);
    endproperty
    a_bflag: assert property (p_bflag) else $error("backup flag while running");
    c_pflag: cover property ($rose(PRIMARY_STOPPED_FLAG));
    c_swap: cover property ($fell(SWITCH_BUSY) && ACTIVE_BACKUP);
    c_ovr: cover property (MODE == rcs_pkg::RCS_MODE_OVERRIDE && !MANUAL_SWITCH_B);
endmodule
bind rcs_top rcs_chk u_chk (.CLK, .RST_B, .REF_IN_PRIMARY, .REF_IN_BACKUP,
    .MANUAL_SWITCH_B, .MODE, .REF_OUT, .PRIMARY_STOPPED_FLAG,
    .BACKUP_STOPPED_FLAG, .ACTIVE_BACKUP, .SWITCH_BUSY);

// File: test_ref_clock_switchover.sv
/* Self-checking bench for rcs_top.
 * Assumes rcs_ref_src and the bound checker are compiled too. */
`timescale 1ns/10ps
module test_ref_clock_switchover;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic en_p = 1'b1;
    logic en_b = 1'b1;
    logic man_b = 1'b1;
    logic [1:0] mode = 2'h1;
    logic [7:0] dly = 8'h00;
    logic ref_p, ref_b, ref_out, pflag, bflag, act, busy;
    logic busy_q = 1'b0;
    logic sel = 1'b0;
    logic slow_bkp = 1'b0;
    logic pll_lock;
    logic [3:0] note;
    // Bit 3 marks the flags as don't-care
    logic [3:0] notes[$];
    wire [2:0] obs = {act, pflag, bflag};
    int miscompares = 0;
    int compares = 0;
    int seed = 31;
    int i;
    rcs_ref_src u_src (.en_p, .en_b, .slow_bkp, .act, .ref_out, .ref_p, .ref_b, .pll_lock);
    rcs_top #(.DLY_W(8)) u_dut (.CLK(clk), .RST_B(rst_b), .REF_IN_PRIMARY(ref_p),
        .REF_IN_BACKUP(ref_b), .MANUAL_SWITCH_B(man_b), .MODE(mode),
        .SWITCH_DELAY(dly), .REF_OUT(ref_out), .PRIMARY_STOPPED_FLAG(pflag),
        .BACKUP_STOPPED_FLAG(bflag), .ACTIVE_BACKUP(act), .SWITCH_BUSY(busy));
    initial
    begin
        forever #2 clk = ~clk;
    end
    task check(input logic [2:0] exp, input logic [2:0] got);
        compares++;
        if (got !== exp)
        begin
            miscompares++;
            $display("BAD t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask
    task check_lock(input logic exp, input logic got);
        compares++;
        if (got !== exp)
        begin
            miscompares++;
            $display("BAD t=%0t lock exp=%h got=%h", $time, exp, got);
        end
    endtask
    task step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Note the outcome, then wait for the monitor to consume it
    // Flags mean nothing while the backup runs slow
    task expect_switch(input logic [2:0] exp);
        notes.push_back({slow_bkp, exp});
        for (i = 0; i < 3000 && notes.size() > 0; i++)
            step(1);
        if (notes.size() > 0)
        begin
            note = notes.pop_front();
            check(note[2:0], 3'hx);
        end
    endtask
    task summarize;
        if (miscompares == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // ==========
    // Every end of a switch, done or aborted, consumes one note
    always @(negedge clk)
    begin
        if (busy_q && busy === 1'b0)
        begin
            note = notes.size() > 0 ? notes.pop_front() : 4'hx;
            check({note[2], note[3] ? obs[1:0] : note[1:0]}, obs);
        end
        busy_q = busy;
    end
    initial
    begin
        #200000;
        miscompares++;
        summarize();
    end
    initial
    begin
        step(12);
        rst_b = 1'b1;
        step(8);
        check(3'h0, obs);
        // Mode 3 neither switches by hand nor on a stopped input
        mode = 2'h3;
        man_b = 1'b0;
        step(20);
        en_p = 1'b0;
        step(100);
        check(3'h2, obs);
        en_p = 1'b1;
        man_b = 1'b1;
        step(60);
        mode = 2'h1;
        for (int k = 0; k < 2; k++)
        begin
            dly = 8'($random(seed) & 3);
            slow_bkp = (k == 0);
            step(30);
            man_b = 1'b0;
            sel = ~sel;
            expect_switch({sel, 2'h0});
            man_b = 1'b1;
            slow_bkp = 1'b0;
            step(80);
            check({sel, 2'h0}, obs);
            check_lock(1'b1, pll_lock);
        end
        man_b = 1'b0;
        step(12);
        man_b = 1'b1;
        expect_switch({sel, 2'h0});
        mode = 2'h2;
        step(8);
        man_b = 1'b0;
        sel = ~sel;
        expect_switch({sel, 2'h0});
        en_b = 1'b0;
        step(150);
        check(3'h5, obs);
        man_b = 1'b1;
        expect_switch(3'h1);
        en_b = 1'b1;
        mode = 2'h0;
        step(60);
        for (int k = 0; k < 2; k++)
        begin
            en_p = 1'b0;
            expect_switch(3'h6);
            en_p = 1'b1;
            step(60);
            en_b = 1'b0;
            expect_switch(3'h1);
            en_b = 1'b1;
            step(60);
        end
        en_b = 1'b0;
        step(150);
        en_p = 1'b0;
        step(150);
        check(3'h1, obs);
        en_b = 1'b1;
        expect_switch(3'h6);
        summarize();
    end
endmodule
